// ---- iotx_pkg.sv ----
package iotx_pkg;

	// Data-space map of the I/O window
	localparam logic [15:0] DS_IO_BASE    = 16'h0020;
	localparam logic [15:0] DS_EXT_BASE   = 16'h0060;
	localparam logic [15:0] ONE16         = 16'h0001;
	localparam logic [5:0]  IO_BIT_LAST   = 6'h1F;
	localparam logic [5:0]  IO_TMR0_FLAGS = 6'h15;
	localparam logic [5:0]  IO_TMR1_FLAGS = 6'h16;
	localparam logic [5:0]  IO_SP_LO      = 6'h3D;
	localparam logic [5:0]  IO_SP_HI      = 6'h3E;
	localparam logic [5:0]  IO_STATUS     = 6'h3F;

	// Status register layout and reset values
	localparam logic [2:0]  FLAG_T        = 3'h6;
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [15:0] STACK_RESET   = 16'h01FF;
	localparam logic [7:0]  IO_RESET      = 8'h00;

	// Low register index of each pointer pair
	localparam logic [4:0]  PTR_X_LO      = 5'h1A;
	localparam logic [4:0]  PTR_Y_LO      = 5'h1C;
	localparam logic [4:0]  PTR_Z_LO      = 5'h1E;

	// Implemented-bit masks
	localparam logic [7:0]  MASK_FULL     = 8'hFF;
	localparam logic [7:0]  MASK_NONE     = 8'h00;
	localparam logic [7:0]  MASK_NIB      = 8'h0F;
	localparam logic [7:0]  MASK_TMR0     = 8'h07;
	localparam logic [7:0]  MASK_TMR1     = 8'h27;

	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_FLAG_SET = 5'h01,
		OP_FLAG_CLR = 5'h02,
		OP_BST      = 5'h03,
		OP_BLD      = 5'h04,
		OP_MOV      = 5'h05,
		OP_LD_IND   = 5'h06,
		OP_ST_IND   = 5'h07,
		OP_LD_DISP  = 5'h08,
		OP_ST_DISP  = 5'h09,
		OP_LD_DIR   = 5'h0A,
		OP_ST_DIR   = 5'h0B,
		OP_LPM      = 5'h0C,
		OP_SPM      = 5'h0D,
		OP_IN       = 5'h0E,
		OP_OUT      = 5'h0F,
		OP_PUSH     = 5'h10,
		OP_POP      = 5'h11,
		OP_SBI      = 5'h12,
		OP_CBI      = 5'h13,
		OP_SKIP_IF_IO_BIT_SET_OP     = 5'h14,
		OP_SKIP_IF_IO_BIT_CLEAR_OP     = 5'h15
	} iotx_op_e;

	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2
	} iotx_ptr_e;

	typedef enum logic [1:0] {
		MODE_PLAIN   = 2'h0,
		MODE_POSTINC = 2'h1,
		MODE_PREDEC  = 2'h2
	} iotx_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_MEM  = 2'h2
	} iotx_state_e;

	// Bits that exist at each I/O address; the rest read zero
	function automatic logic [7:0] ioMask(input logic [5:0] a);
		logic [7:0] m;
		m = MASK_NONE;
		case (a) inside
			[6'h03:6'h0B], 6'h12, [6'h1B:6'h3C]: m = MASK_FULL;
			[6'h0C:6'h0E]: m = MASK_NIB;
			IO_TMR0_FLAGS: m = MASK_TMR0;
			IO_TMR1_FLAGS: m = MASK_TMR1;
			default: m = MASK_NONE;
		endcase
		return m;
	endfunction : ioMask

	function automatic logic isW1c(input logic [5:0] a);
		return (a == IO_TMR0_FLAGS) || (a == IO_TMR1_FLAGS);
	endfunction : isW1c

	function automatic logic [4:0] ptrBase(input iotx_ptr_e p);
		case (p)
			PTR_Y: return PTR_Y_LO;
			PTR_Z: return PTR_Z_LO;
			default: return PTR_X_LO;
		endcase
	endfunction : ptrBase

	function automatic logic isLoad(input iotx_op_e o);
		return o inside {OP_LD_IND, OP_LD_DISP, OP_LD_DIR, OP_POP};
	endfunction : isLoad

	function automatic logic isStore(input iotx_op_e o);
		return o inside {OP_ST_IND, OP_ST_DISP, OP_ST_DIR, OP_PUSH};
	endfunction : isStore

endpackage : iotx_pkg

// ---- iotx_io_if.sv ----
interface iotx_io_if;
	logic [5:0] addr;  // I/O address
	logic       we;    // Whole-byte write
	logic [7:0] wdata; // Byte written
	logic       bitWe; // Single-bit write
	logic [2:0] bitSel;
	logic       bitVal;
	logic [7:0] rdata; // Masked read data

	modport core (output addr, we, wdata, bitWe, bitSel, bitVal, input rdata);
	modport space (input addr, we, wdata, bitWe, bitSel, bitVal, output rdata);
endinterface : iotx_io_if

// ---- iotx_io_space.sv ----
module iotx_io_space #(
	parameter int unsigned DEPTH = 64
) (
	input  wire logic        clock,     // Core clock
	input  wire logic        arst_n,    // Async reset, active low
	iotx_io_if.space         io,        // Access port from the core
	input  wire logic [15:0] hwFlagSet  // Timer flag set events
);

	logic [7:0] mem    [DEPTH];
	logic [7:0] nxtMem [DEPTH];

	// Read returns stored bits, already masked
	assign io.rdata = mem[io.addr];

	// Next value of every location
	always_comb begin
		logic [7:0] onehot;
		logic [7:0] clr;
		onehot = 8'h01 << io.bitSel;
		clr    = io.bitWe ? (io.bitVal ? onehot : iotx_pkg::MASK_NONE) : io.wdata;
		for (int i = 0; i < DEPTH; i++) begin
			nxtMem[i] = mem[i];
			if (6'(i) == io.addr && (io.we || io.bitWe)) begin
				if (iotx_pkg::isW1c(6'(i)))
					nxtMem[i] = mem[i] & ~clr;
				else if (io.bitWe)
					nxtMem[i] = io.bitVal ? (mem[i] | onehot) : (mem[i] & ~onehot);
				else
					nxtMem[i] = io.wdata;
			end
			// Hardware set beats a same-cycle clear
			if (6'(i) == iotx_pkg::IO_TMR0_FLAGS)
				nxtMem[i] = nxtMem[i] | hwFlagSet[7:0];
			if (6'(i) == iotx_pkg::IO_TMR1_FLAGS)
				nxtMem[i] = nxtMem[i] | hwFlagSet[15:8];
			nxtMem[i] = nxtMem[i] & iotx_pkg::ioMask(6'(i));
		end
	end

	// Storage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= iotx_pkg::IO_RESET;
		end else begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= nxtMem[i];
		end
	end

endmodule : iotx_io_space

// ---- iotx_core.sv ----
// Operation
// - Bit set, clear and skip tests reach I/O addresses 0x00 to 0x1F.
// - Bit set or clear changes only the named bit of the register.
// - Timer flag bits at I/O 0x15 and 0x16 clear on a written one; zero leaves them.
// - Port in and out use a 6-bit I/O address, one cycle each.
// - Data-space address of an I/O register is its I/O address plus 0x20.
// - Extended I/O 0x60 to 0xFF only by data-space loads and stores.
// - Transfer-bit store copies a register bit into T in one cycle.
// - Transfer-bit load copies T into a register bit, flags untouched.
// - Flag set and clear ops change one status flag in one cycle.
// - Overflow flag set and clear ops touch only that flag.
// - Indirect access takes two cycles; post-increment adds one afterwards.
// - Pre-decrement subtracts one first and uses the new pointer.
// - Displaced access uses Y or Z plus offset, pointer kept, two cycles.
// - Direct access to an absolute address takes two cycles, flags kept.
// - Program-memory load reads byte at Z in three cycles, optional increment.
// - Push and pop move a register via the stack in two cycles.
module iotx_core (
	input  wire logic               clock,       // Core clock, 10 MHz
	input  wire logic               arst_n,      // Async reset, active low
	input  wire logic               opValid,     // Operation offered
	input  wire iotx_pkg::iotx_op_e   opCode,      // Operation kind
	input  wire logic [4:0]         opRd,        // Destination register
	input  wire logic [4:0]         opRr,        // Source register
	input  wire logic [2:0]         opBit,       // Bit or flag index
	input  wire iotx_pkg::iotx_ptr_e  opPtr,       // Pointer pair
	input  wire iotx_pkg::iotx_mode_e opMode,      // Pointer adjust
	input  wire logic [5:0]         opDisp,      // Displacement
	input  wire logic [15:0]        opAddr,      // Absolute or I/O address
	input  wire logic [15:0]        hwFlagSet,   // Timer flag set events
	input  wire logic [7:0]         dataRdData,  // Data memory read byte
	input  wire logic [15:0]        progRdData,  // Program memory word
	output logic                    ready_r,     // Idle, op may be offered
	output logic                    done_r,      // Op finished pulse
	output logic                    skip_r,      // Bit test says skip
	output logic [7:0]              status_r,    // Status flags
	output logic [15:0]             dataAddr_r,  // Data memory address
	output logic [7:0]              dataWdata_r, // Data memory write byte
	output logic                    dataWe_r,    // Data memory write
	output logic                    dataRe_r,    // Data memory read
	output logic [14:0]             progAddr_r,  // Program word address
	output logic [15:0]             progWdata_r, // Program write word
	output logic                    progWe_r,    // Program write strobe
	output logic                    progRe_r     // Program read strobe
);

	iotx_io_if io ();

	iotx_pkg::iotx_state_e state_r;
	iotx_pkg::iotx_state_e state_nxt;
	iotx_pkg::iotx_op_e    curOp_r;
	logic [4:0]          curRd_r;
	logic [15:0]         curAddr_r;
	logic [7:0]          curData_r;
	logic                curByte_r;
	logic [15:0]         stackPtr_r;
	logic [7:0]          regFile [32];

	logic                accept;
	iotx_pkg::iotx_ptr_e   ptrSel;
	logic [4:0]          ptrLo;
	logic [15:0]         ptrCur;
	logic [15:0]         ptrNew;
	logic                ptrWe;
	logic [15:0]         effAddr;
	logic [15:0]         spAddr;
	logic [5:0]          ioIdx;
	logic                inRegs;
	logic                inIo;
	logic [7:0]          rdByte;
	logic                wrEn;
	logic [7:0]          wrData;
	logic                rfWe;
	logic [4:0]          rfWa;
	logic [7:0]          rfWd;
	logic                bitTest;

	iotx_io_space #(
		.DEPTH(64)
	) u_space (
		.clock     (clock),
		.arst_n    (arst_n),
		.io        (io.space),
		.hwFlagSet (hwFlagSet)
	);

	assign accept = (state_r == iotx_pkg::ST_IDLE) && opValid;

	// Pointer selection; program-memory ops always use Z
	always_comb begin
		ptrSel = opPtr;
		if (opCode == iotx_pkg::OP_LPM || opCode == iotx_pkg::OP_SPM)
			ptrSel = iotx_pkg::PTR_Z;
		ptrLo  = iotx_pkg::ptrBase(ptrSel);
		ptrCur = {regFile[ptrLo + 5'h01], regFile[ptrLo]};
	end

	// Effective address and pointer update
	always_comb begin
		effAddr = opAddr;
		ptrNew  = ptrCur;
		ptrWe   = 1'b0;
		case (opCode)
			iotx_pkg::OP_LD_IND, iotx_pkg::OP_ST_IND: begin
				effAddr = ptrCur;
				if (opMode == iotx_pkg::MODE_PREDEC) begin
					ptrNew  = ptrCur - iotx_pkg::ONE16;
					effAddr = ptrNew;
					ptrWe   = 1'b1;
				end
				if (opMode == iotx_pkg::MODE_POSTINC) begin
					ptrNew = ptrCur + iotx_pkg::ONE16;
					ptrWe  = 1'b1;
				end
			end
			iotx_pkg::OP_LD_DISP, iotx_pkg::OP_ST_DISP: begin
				effAddr = ptrCur + {10'h000, opDisp};
			end
			iotx_pkg::OP_LD_DIR, iotx_pkg::OP_ST_DIR: begin
				effAddr = opAddr;
			end
			iotx_pkg::OP_PUSH: effAddr = stackPtr_r;
			iotx_pkg::OP_POP:  effAddr = stackPtr_r + iotx_pkg::ONE16;
			iotx_pkg::OP_LPM: begin
				effAddr = ptrCur;
				if (opMode == iotx_pkg::MODE_POSTINC) begin
					ptrNew = ptrCur + iotx_pkg::ONE16;
					ptrWe  = 1'b1;
				end
			end
			default: effAddr = opAddr;
		endcase
	end

	// Data-space address in use this cycle and its decode
	always_comb begin
		// I/O seen at I/O address plus offset
		spAddr = curAddr_r;
		if (state_r == iotx_pkg::ST_IDLE) begin
			// bit ops reach only the low 32
			if (opCode inside {iotx_pkg::OP_SBI, iotx_pkg::OP_CBI,
					iotx_pkg::OP_SKIP_IF_IO_BIT_SET_OP, iotx_pkg::OP_SKIP_IF_IO_BIT_CLEAR_OP})
				spAddr = {10'h000, opAddr[5:0] & iotx_pkg::IO_BIT_LAST}
					+ iotx_pkg::DS_IO_BASE;
			else
				spAddr = {10'h000, opAddr[5:0]} + iotx_pkg::DS_IO_BASE;
		end
		inRegs = spAddr < iotx_pkg::DS_IO_BASE;
		// extended range falls to the memory port
		inIo   = !inRegs && (spAddr < iotx_pkg::DS_EXT_BASE);
		ioIdx  = 6'(spAddr - iotx_pkg::DS_IO_BASE);
	end

	// Byte read from the decoded location
	always_comb begin
		rdByte = dataRdData;
		if (inRegs)
			rdByte = regFile[spAddr[4:0]];
		else if (inIo) begin
			case (ioIdx)
				iotx_pkg::IO_STATUS: rdByte = status_r;
				iotx_pkg::IO_SP_HI:  rdByte = stackPtr_r[15:8];
				iotx_pkg::IO_SP_LO:  rdByte = stackPtr_r[7:0];
				default:           rdByte = io.rdata;
			endcase
		end
		bitTest = rdByte[opBit];
	end

	// Byte writes into the register or I/O window
	always_comb begin
		wrEn   = 1'b0;
		wrData = curData_r;
		if (accept && opCode == iotx_pkg::OP_OUT) begin
			wrEn   = 1'b1;
			wrData = regFile[opRr];
		end
		if (state_r == iotx_pkg::ST_MEM && iotx_pkg::isStore(curOp_r))
			wrEn = 1'b1;
	end

	// Access port toward the I/O space
	always_comb begin
		io.addr   = ioIdx;
		io.wdata  = wrData;
		io.we     = wrEn && inIo;
		io.bitWe  = accept && inIo
			&& (opCode == iotx_pkg::OP_SBI || opCode == iotx_pkg::OP_CBI);
		io.bitSel = opBit;
		io.bitVal = opCode == iotx_pkg::OP_SBI;
	end

	// Register file write source
	always_comb begin
		rfWe = 1'b0;
		rfWa = opRd;
		rfWd = regFile[opRr];
		if (accept) begin
			case (opCode)
				iotx_pkg::OP_BLD: begin
					rfWe = 1'b1;
					rfWd = regFile[opRd];
					rfWd[opBit] = status_r[iotx_pkg::FLAG_T];
				end
				iotx_pkg::OP_MOV: rfWe = 1'b1;
				iotx_pkg::OP_IN: begin
					rfWe = 1'b1;
					rfWd = rdByte;
				end
				default: rfWe = 1'b0;
			endcase
		end else if (state_r == iotx_pkg::ST_MEM) begin
			rfWa = curRd_r;
			if (curOp_r == iotx_pkg::OP_LPM) begin
				rfWe = 1'b1;
				rfWd = curByte_r ? progRdData[15:8] : progRdData[7:0];
			end else if (iotx_pkg::isLoad(curOp_r)) begin
				rfWe = 1'b1;
				rfWd = rdByte;
			end else if (wrEn && inRegs) begin
				rfWe = 1'b1;
				rfWa = spAddr[4:0];
				rfWd = wrData;
			end
		end
	end

	// General registers; a data write wins over a pointer update
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 32; i++)
				regFile[i] <= 8'h00;
		end else begin
			if (accept && ptrWe) begin
				regFile[ptrLo]         <= ptrNew[7:0];
				regFile[ptrLo + 5'h01] <= ptrNew[15:8];
			end
			if (rfWe)
				regFile[rfWa] <= rfWd;
		end
	end

	// Status flags
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_r <= iotx_pkg::STATUS_RESET;
		end else if (accept && opCode == iotx_pkg::OP_FLAG_SET) begin
			status_r[opBit] <= 1'b1;
		end else if (accept && opCode == iotx_pkg::OP_FLAG_CLR) begin
			status_r[opBit] <= 1'b0;
		end else if (accept && opCode == iotx_pkg::OP_BST) begin
			status_r[iotx_pkg::FLAG_T] <= regFile[opRr][opBit];
		end else if (wrEn && inIo && ioIdx == iotx_pkg::IO_STATUS) begin
			status_r <= wrData;
		end
	end

	// Stack pointer; push and pop move it at acceptance
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stackPtr_r <= iotx_pkg::STACK_RESET;
		end else if (accept && opCode == iotx_pkg::OP_PUSH) begin
			stackPtr_r <= stackPtr_r - iotx_pkg::ONE16;
		end else if (accept && opCode == iotx_pkg::OP_POP) begin
			stackPtr_r <= effAddr;
		end else if (wrEn && inIo && ioIdx == iotx_pkg::IO_SP_HI) begin
			stackPtr_r[15:8] <= wrData;
		end else if (wrEn && inIo && ioIdx == iotx_pkg::IO_SP_LO) begin
			stackPtr_r[7:0] <= wrData;
		end
	end

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			iotx_pkg::ST_IDLE: begin
				if (accept && (iotx_pkg::isLoad(opCode) || iotx_pkg::isStore(opCode)))
					state_nxt = iotx_pkg::ST_MEM;
				else if (accept && opCode == iotx_pkg::OP_LPM)
					state_nxt = iotx_pkg::ST_WAIT;
			end
			iotx_pkg::ST_WAIT: state_nxt = iotx_pkg::ST_MEM;
			iotx_pkg::ST_MEM:  state_nxt = iotx_pkg::ST_IDLE;
			default:         state_nxt = iotx_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state and handshake
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= iotx_pkg::ST_IDLE;
			ready_r <= 1'b1;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ready_r <= state_nxt == iotx_pkg::ST_IDLE;
			// two-cycle ops end in the memory state
			done_r  <= (accept && state_nxt == iotx_pkg::ST_IDLE)
				|| state_r == iotx_pkg::ST_MEM;
		end
	end

	// Operation context held across the memory cycles
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			curOp_r   <= iotx_pkg::OP_NOP;
			curRd_r   <= 5'h00;
			curAddr_r <= 16'h0000;
			curData_r <= 8'h00;
			curByte_r <= 1'b0;
		end else if (accept) begin
			curOp_r   <= opCode;
			curRd_r   <= opRd;
			curAddr_r <= effAddr;
			curData_r <= regFile[opRr];
			curByte_r <= effAddr[0];
		end
	end

	// Skip result of bit tests, one cycle with done
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			skip_r <= 1'b0;
		else if (accept && opCode == iotx_pkg::OP_SKIP_IF_IO_BIT_SET_OP)
			skip_r <= bitTest;
		else if (accept && opCode == iotx_pkg::OP_SKIP_IF_IO_BIT_CLEAR_OP)
			skip_r <= !bitTest;
		else
			skip_r <= 1'b0;
	end

	// Data memory strobes for addresses outside the windows
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dataAddr_r  <= 16'h0000;
			dataWdata_r <= 8'h00;
			dataWe_r    <= 1'b0;
			dataRe_r    <= 1'b0;
		end else begin
			dataWe_r <= 1'b0;
			dataRe_r <= 1'b0;
			if (accept && effAddr >= iotx_pkg::DS_EXT_BASE) begin
				dataAddr_r  <= effAddr;
				dataWdata_r <= regFile[opRr];
				dataWe_r    <= iotx_pkg::isStore(opCode);
				dataRe_r    <= iotx_pkg::isLoad(opCode);
			end
		end
	end

	// Program memory strobes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			progAddr_r  <= 15'h0000;
			progWdata_r <= 16'h0000;
			progWe_r    <= 1'b0;
			progRe_r    <= 1'b0;
		end else begin
			progRe_r <= accept && opCode == iotx_pkg::OP_LPM;
			progWe_r <= accept && opCode == iotx_pkg::OP_SPM;
			if (accept && (opCode == iotx_pkg::OP_LPM || opCode == iotx_pkg::OP_SPM)) begin
				progAddr_r  <= ptrCur[15:1];
				progWdata_r <= {regFile[5'h01], regFile[5'h00]};
			end
		end
	end

endmodule : iotx_core

// ---- iotx_mem_model.sv ----
module iotx_mem_model (
	input  wire logic        clock,      // Core clock
	input  wire logic [15:0] dataAddr,   // Data address
	input  wire logic [7:0]  dataWdata,  // Byte to store
	input  wire logic        dataWe,     // Store strobe
	input  wire logic        dataRe,     // Load strobe
	input  wire logic [14:0] progAddr,   // Program word address
	input  wire logic        progRe,     // Program read strobe
	output logic      [7:0]  dataRdData, // Load byte
	output logic      [15:0] progRdData  // Program word
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:511];
	logic       junk;

	// Preset contents; each byte is the inverse of its address
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = ~8'(i);
		end
		junk = 1'b0;
		progRdData = 16'h0000;
	end

	// Stores land at the edge; junk toggles so idle reads never look valid
	always @(posedge clock) begin
		junk <= ~junk;
		if (dataWe) begin
			mem[dataAddr[8:0]] <= dataWdata;
		end
	end

	// Load byte only while the strobe stands, a moving pattern otherwise
	assign dataRdData = dataRe ? mem[dataAddr[8:0]] : {8{junk}};

	// Word arrives one edge after the strobe and lasts one cycle
	always @(posedge clock) begin
		progRdData <= progRe ? {progAddr[7:0] ^ 8'hA5, progAddr[7:0]} : ~progRdData;
	end
endmodule : iotx_mem_model

// ---- iotx_core_chk.sv ----
module iotx_core_chk (
	input  wire logic               clock,      // Core clock
	input  wire logic               arst_n,     // Async reset, active low
	input  wire logic               opValid,    // Op offered
	input  wire iotx_pkg::iotx_op_e opCode,     // Op kind
	input  wire logic [2:0]         opBit,      // Flag index
	input  wire logic               ready_r,    // Idle
	input  wire logic               done_r,     // Finished pulse
	input  wire logic               skip_r,     // Skip pulse
	input  wire logic [7:0]         status_r,   // Status flags
	input  wire logic [15:0]        dataAddr_r, // Data address
	input  wire logic               dataWe_r,   // Store pulse
	input  wire logic               dataRe_r,   // Load pulse
	input  wire logic               progRe_r    // Program read pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Accept edge and the program-read walk
	sequence s_take;
		opValid && ready_r;
	endsequence
	sequence s_lpm;
		progRe_r && !done_r ##1 !done_r ##1 done_r;
	endsequence

	property p_one_cycle;
		s_take ##0 (opCode inside {iotx_pkg::OP_FLAG_SET, iotx_pkg::OP_FLAG_CLR,
			iotx_pkg::OP_BST, iotx_pkg::OP_BLD, iotx_pkg::OP_IN, iotx_pkg::OP_OUT})
			|=> done_r && ready_r;
	endproperty
	property p_two_cycle;
		s_take ##0 (iotx_pkg::isLoad(opCode) || iotx_pkg::isStore(opCode))
			|=> !done_r && !ready_r ##1 done_r;
	endproperty
	property p_lpm;
		s_take ##0 opCode == iotx_pkg::OP_LPM |=> s_lpm;
	endproperty
	property p_flag_set;
		s_take ##0 opCode == iotx_pkg::OP_FLAG_SET
			|=> status_r == ($past(status_r) | (8'h01 << $past(opBit)));
	endproperty
	property p_flag_clr;
		s_take ##0 opCode == iotx_pkg::OP_FLAG_CLR
			|=> status_r == ($past(status_r) & ~(8'h01 << $past(opBit)));
	endproperty
	property p_bst;
		s_take ##0 opCode == iotx_pkg::OP_BST |=> (status_r & 8'hBF) == ($past(status_r) & 8'hBF);
	endproperty
	property p_bld;
		s_take ##0 opCode == iotx_pkg::OP_BLD |=> $stable(status_r);
	endproperty
	property p_mem_flags;
		s_take ##0 (iotx_pkg::isLoad(opCode) || iotx_pkg::isStore(opCode)) |=> $stable(status_r) [*2];
	endproperty
	property p_ext_port;
		dataRe_r || dataWe_r |-> dataAddr_r >= 16'h0060;
	endproperty
	property p_skip;
		skip_r |-> done_r;
	endproperty

	// Each label carries what it guards
	a_one_cycle: assert property (p_one_cycle) else $error("one-cycle op late");
	a_two_cycle: assert property (p_two_cycle) else $error("memory op not two cycles");
	a_lpm: assert property (p_lpm) else $error("program load not three cycles");
	a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
	a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
	a_bst: assert property (p_bst) else $error("transfer store touched flags");
	a_bld: assert property (p_bld) else $error("transfer load touched flags");
	a_mem_flags: assert property (p_mem_flags) else $error("memory op touched flags");
	a_ext_port: assert property (p_ext_port) else $error("low address on data port");
	a_skip: assert property (p_skip) else $error("skip without done");
endmodule : iotx_core_chk

bind iotx_core iotx_core_chk u_chk (.clock, .arst_n, .opValid, .opCode, .opBit, .ready_r,
	.done_r, .skip_r, .status_r, .dataAddr_r, .dataWe_r, .dataRe_r, .progRe_r);

// ---- io_space_bit_and_transfer_execution_tb.sv ----
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module io_space_bit_and_transfer_execution_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import iotx_pkg::*;
	logic                 clock, arst_n, opValid, ready_r, done_r, skip_r;
	logic                 dataWe_r, dataRe_r, progWe_r, progRe_r;
	iotx_op_e             opCode;
	iotx_ptr_e            opPtr;
	iotx_mode_e           opMode;
	logic [4:0]           opRd, opRr;
	logic [2:0]           opBit;
	logic [5:0]           opDisp;
	logic [15:0]          opAddr, hwFlagSet, progRdData, dataAddr_r, progWdata_r;
	logic [7:0]           dataRdData, status_r, dataWdata_r;
	logic [14:0]          progAddr_r;
	int                   fails, nCompared, cyc;

	iotx_core uut (.clock, .arst_n, .opValid, .opCode, .opRd, .opRr, .opBit, .opPtr,
		.opMode, .opDisp, .opAddr, .hwFlagSet, .dataRdData, .progRdData, .ready_r,
		.done_r, .skip_r, .status_r, .dataAddr_r, .dataWdata_r, .dataWe_r, .dataRe_r,
		.progAddr_r, .progWdata_r, .progWe_r, .progRe_r);
	iotx_mem_model mem (.clock, .dataAddr(dataAddr_r), .dataWdata(dataWdata_r),
		.dataWe(dataWe_r), .dataRe(dataRe_r), .progAddr(progAddr_r), .progRe(progRe_r),
		.dataRdData, .progRdData);

	// Free-running clock, 100 ns period
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end

	task automatic results();
		$display("compared %0d, wrong %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Offer one op and check its latency; valid is held for one-cycle ops
	task automatic go(input iotx_op_e op, input int lat);
		int c;
		c = 1;
		opCode = op;
		opValid = 1'b1;
		@(posedge clock);
		#1;
		if (done_r !== 1'b1) opValid = 1'b0;
		while (done_r !== 1'b1 && c < 9) begin
			@(posedge clock);
			#1 c++;
		end
		`CHK(c, lat)
	endtask : go

	task automatic ld(input logic [4:0] r, input logic [15:0] a);
		opRd = r;
		opAddr = a;
		go(OP_LD_DIR, 2);
	endtask : ld

	// A register is read back by storing it to an external byte
	task automatic rdReg(input logic [4:0] r, input logic [7:0] e);
		opRr = r;
		opAddr = 16'h0080;
		go(OP_ST_DIR, 2);
		`CHK(dataWdata_r, e)
	endtask : rdReg

	task automatic tFlags();
		logic [7:0] e;
		e = 8'h00;
		for (int b = 0; b < 16; b++) begin
			opBit = 3'(b);
			e[b % 8] = (b < 8);
			go(b < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 1);
			`CHK(status_r, e)
		end
	endtask : tFlags

	task automatic tTransferBit();
		ld(5'd16, 16'h0061);
		ld(5'd17, 16'h0062);
		opRr = 5'd16;
		opBit = 3'd3;
		go(OP_BST, 1);
		`CHK(status_r, 8'h40)
		opRd = 5'd17;
		opBit = 3'd6;
		go(OP_BLD, 1);
		opBit = 3'd0;
		go(OP_BST, 1);
		`CHK(status_r, 8'h00)
		rdReg(5'd17, 8'hDD);
	endtask : tTransferBit

	task automatic tIndirect();
		ld(5'd28, 16'h006F);
		opRd = 5'd20;
		opPtr = PTR_Y;
		opMode = MODE_POSTINC;
		go(OP_LD_IND, 2);
		`CHK(dataAddr_r, 16'h0090)
		opRd = 5'd21;
		opMode = MODE_PREDEC;
		go(OP_LD_IND, 2);
		`CHK(dataAddr_r, 16'h0090)
		opRd = 5'd22;
		opDisp = 6'h05;
		opMode = MODE_PLAIN;
		go(OP_LD_DISP, 2);
		`CHK(dataAddr_r, 16'h0095)
		opRr = 5'd20;
		opMode = MODE_POSTINC;
		go(OP_ST_IND, 2);
		`CHK(dataAddr_r, 16'h0090)
		opMode = MODE_PREDEC;
		go(OP_ST_IND, 2);
		`CHK(dataAddr_r, 16'h0090)
		rdReg(5'd21, 8'h6F);
		rdReg(5'd22, 8'h6A);
	endtask : tIndirect

	task automatic tIoSpace();
		opRr = 5'd20;
		opAddr = 16'h000B;
		go(OP_OUT, 1);
		ld(5'd23, 16'h002B);
		rdReg(5'd23, 8'h6F);
		opAddr = 16'h000B;
		opBit = 3'd7;
		go(OP_SBI, 1);
		opBit = 3'd0;
		go(OP_CBI, 1);
		go(OP_SKIP_IF_IO_BIT_CLEAR_OP, 1);
		`CHK(skip_r, 1'b1)
		go(OP_SKIP_IF_IO_BIT_SET_OP, 1);
		`CHK(skip_r, 1'b0)
		opRd = 5'd24;
		go(OP_IN, 1);
		rdReg(5'd24, 8'hEE);
		// Timer flags raised for one edge, then one cleared by a written one
		opValid = 1'b0;
		hwFlagSet = 16'h0007;
		@(posedge clock);
		#1 hwFlagSet = 16'h0000;
		opAddr = 16'h0015;
		go(OP_SBI, 1);
		opBit = 3'd1;
		go(OP_CBI, 1);
		opRd = 5'd25;
		go(OP_IN, 1);
		rdReg(5'd25, 8'h06);
		opRd = 5'd20;
		opAddr = 16'h0002;
		go(OP_IN, 1);
		rdReg(5'd20, 8'h00);
	endtask : tIoSpace

	task automatic tLpmStack();
		ld(5'd30, 16'h00EC);
		opRd = 5'd0;
		opMode = MODE_POSTINC;
		go(OP_LPM, 3);
		`CHK(progAddr_r, 15'h0009)
		rdReg(5'd0, 8'hAC);
		opRd = 5'd26;
		opMode = MODE_PLAIN;
		go(OP_LPM, 3);
		`CHK(progAddr_r, 15'h000A)
		rdReg(5'd26, 8'h0A);
		opRr = 5'd21;
		go(OP_PUSH, 2);
		`CHK(dataAddr_r, 16'h01FF)
		opRd = 5'd27;
		go(OP_POP, 2);
		`CHK(dataAddr_r, 16'h01FF)
		rdReg(5'd27, 8'h6F);
		// Register move, then a program write of r1:r0 at Z
		opRd = 5'd19;
		opRr = 5'd27;
		go(OP_MOV, 1);
		rdReg(5'd19, 8'h6F);
		go(OP_SPM, 1);
		`CHK(progWe_r, 1'b1)
		`CHK(progWdata_r, 16'h00AC)
		`CHK(progAddr_r, 15'h000A)
	endtask : tLpmStack

	// Reset for five cycles, then the scenarios in turn
	initial begin
		{arst_n, opValid, opRd, opRr, opBit, opDisp} = '0;
		{opAddr, hwFlagSet, fails, nCompared, cyc} = '0;
		opCode = OP_NOP;
		opPtr = PTR_X;
		opMode = MODE_PLAIN;
		repeat (5) @(posedge clock);
		#1 arst_n = 1'b1;
		tFlags();
		tTransferBit();
		tIndirect();
		tIoSpace();
		tLpmStack();
		opValid = 1'b0;
		results();
	end
endmodule : io_space_bit_and_transfer_execution_tb
